//--- src/abt_device.sv
// Summary of operation
// RULE_01: watchdog: input high loads preload, counts down
// RULE_02: input drops early: flag and output stay clear
// RULE_03: zero while high: flag, output set; roll
// RULE_04: input low: clear flag, output, halt, prescaler ones
// RULE_05: host halts timer before reading the counter
// RULE_06: event mode counts input pulses while running
// RULE_07: host asserts only one strobe at once
// RULE_08: acknowledge cycles ignore register select inputs
// RULE_09: select edge captures selects, direction, write data
// RULE_10: acknowledge and read data one edge after recognition
// RULE_11: read data held while select stays asserted
// RULE_12: next select recognised three clocks after acknowledge
// RULE_13: four-clock normal cycle, five for acknowledge cycles
// RULE_14: select release drives acknowledge high, then releases
// RULE_15: host holds selects and data until acknowledge
// RULE_16: select latch transparent while ready for select
// RULE_17: acknowledge input synced, vector next, acknowledge after
// RULE_18: acknowledge input release ends acknowledge, then tri-state
// RULE_19: device clock supplied continuously, never gated
// RULE_20: flag set on one-to-zero; clearing wins
// RULE_21: timer acknowledge returns timer vector register value
// RULE_22: port acknowledge returns port vector, same timing
module abt_device (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  abt_bus_if.dev bus,
  input wire logic i_timer_input,
  output logic o_timer_output
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEN = 3'b001,
    ST_ACK = 3'b010,
    ST_IAK_SYNC = 3'b011,
    ST_IAK_VEC = 3'b100,
    ST_REC = 3'b101
  } abt_bus_state_t;

  abt_bus_state_t state_q, state_d;
  logic [4:0] rs_q;
  logic rw_n_q;
  logic [7:0] wdata_q;
  logic iack_port_q;
  logic [7:0] rdata_q;
  logic data_oe_q;
  logic ack_q;
  logic pull_q;
  logic [1:0] rec_q;
  logic [7:0] tctrl_q, tvec_q, pvec_q;
  logic [23:0] cpr_q, cnt_q;
  logic [4:0] pre_q;
  logic zds_q;
  logic tin_q;

  // bus status decode
  wire cs_act = ~bus.chip_select_n;
  wire iack_act = ~bus.port_int_ack_n | ~bus.timer_int_ack_n;
  wire ready = (state_q == ST_IDLE);
  wire strobe_gone = ~cs_act & ~iack_act;
  wire ack_edge = (state_q == ST_SEEN) | (state_q == ST_IAK_VEC);
  wire wr_stb = (state_q == ST_SEEN) & ~rw_n_q;
  wire rec_done = (rec_q >= abt_pkg::RECOVERY_CLKS - 2'h1);

  // register read decode; unmapped selects read zero
  function automatic logic [7:0] rd_sel(input logic [4:0] a, input logic [7:0] pv, input logic [7:0] tc,
                                         input logic [7:0] tv, input logic [23:0] cp, input logic [23:0] cn,
                                         input logic zd);
    logic [7:0] r;
    r = 8'h00;
    if (a == abt_pkg::RS_PORT_VEC) begin
      r = pv;
    end else if (a == abt_pkg::RS_TCTRL) begin
      r = tc;
    end else if (a == abt_pkg::RS_TVEC) begin
      r = tv;
    end else if (a == abt_pkg::RS_CPR_H) begin
      r = cp[23:16];
    end else if (a == abt_pkg::RS_CPR_M) begin
      r = cp[15:8];
    end else if (a == abt_pkg::RS_CPR_L) begin
      r = cp[7:0];
    end else if (a == abt_pkg::RS_CNT_H) begin
      r = cn[23:16];
    end else if (a == abt_pkg::RS_CNT_M) begin
      r = cn[15:8];
    end else if (a == abt_pkg::RS_CNT_L) begin
      r = cn[7:0];
    end else if (a == abt_pkg::RS_TSTAT) begin
      r = {7'h00, zd};
    end
    return r;
  endfunction : rd_sel

  // counter not latched on reads: a running count may tear across bytes
  wire [7:0] reg_rdata = rd_sel(rs_q, pvec_q, tctrl_q, tvec_q, cpr_q, cnt_q, zds_q);
  wire [7:0] vec_rdata = iack_port_q ? pvec_q : tvec_q; // RULE_21 RULE_22

  // bus sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_act) begin
          state_d = ST_SEEN; // RULE_10
        end else if (iack_act) begin
          state_d = ST_IAK_SYNC; // RULE_08 RULE_17
        end
      end
      ST_SEEN: begin
        state_d = ST_ACK;
      end
      ST_IAK_SYNC: begin
        state_d = ST_IAK_VEC;
      end
      ST_IAK_VEC: begin
        state_d = ST_ACK;
      end
      ST_ACK: begin
        if (strobe_gone) begin
          state_d = rec_done ? ST_IDLE : ST_REC; // RULE_12 RULE_18
        end
      end
      ST_REC: begin
        if (rec_done) begin
          state_d = ST_IDLE; // RULE_12 RULE_13
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // select latch: follows the pins while ready, frozen from recognition
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rs_q <= 5'h00;
      rw_n_q <= 1'b1;
      wdata_q <= 8'h00;
      iack_port_q <= 1'b0;
    end else if (ready) begin
      rs_q <= bus.register_select; // RULE_09 RULE_16
      rw_n_q <= bus.read_write_n;
      wdata_q <= bus.data;
      iack_port_q <= ~bus.port_int_ack_n;
    end
  end

  // recovery count: edges since the acknowledge edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rec_q <= 2'h0;
    end else if (ack_edge) begin
      rec_q <= 2'h0;
    end else if (!rec_done) begin
      rec_q <= rec_q + 2'h1; // RULE_12
    end
  end

  // data and acknowledge drivers
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
      data_oe_q <= 1'b0;
      ack_q <= 1'b0;
      pull_q <= 1'b0;
    end else begin
      if (state_q == ST_SEEN && rw_n_q) begin
        rdata_q <= reg_rdata; // RULE_10 RULE_11
        data_oe_q <= 1'b1;
      end else if (state_q == ST_IAK_SYNC) begin
        rdata_q <= vec_rdata; // RULE_17
        data_oe_q <= 1'b1;
      end else if (strobe_gone) begin
        data_oe_q <= 1'b0;
      end
      if (ack_edge) begin
        ack_q <= 1'b1; // RULE_10 RULE_17
      end else if (strobe_gone) begin
        ack_q <= 1'b0;
      end
      // pull-up held one clock after release, then tri-state
      pull_q <= ack_q & strobe_gone; // RULE_14 RULE_18
    end
  end

  // acknowledge goes high the moment the strobe lifts, without a clock
  assign bus.transfer_ack_o = ~(ack_q & ~strobe_gone); // RULE_14 RULE_18
  assign bus.transfer_ack_oe = ack_q | pull_q;
  assign bus.dev_data_oe = data_oe_q & ~strobe_gone;
  assign bus.dev_data_o = rdata_q;

  // timer control decode
  wire tin_rise = i_timer_input & ~tin_q;
  wire tin_fall = ~i_timer_input & tin_q;
  wire wdog = tctrl_q[abt_pkg::TC_WDOG];
  wire event_mode = tctrl_q[abt_pkg::TC_CLK_HI];
  wire no_pre = tctrl_q[abt_pkg::TC_CLK_LO];
  wire run = tctrl_q[abt_pkg::TC_ENABLE] & (~wdog | i_timer_input); // RULE_01 RULE_04
  wire src_tick = event_mode ? tin_rise : 1'b1; // RULE_06
  wire pre_wrap = (pre_q == 5'h00);
  wire cnt_tick = run & src_tick & (no_pre | pre_wrap);
  wire wdog_start = wdog & tctrl_q[abt_pkg::TC_ENABLE] & tin_rise;
  wire wdog_stop = wdog & tin_fall;
  wire zd_hit = cnt_tick & (cnt_q == abt_pkg::CNT_ONE);
  wire zs_wr = wr_stb & (rs_q == abt_pkg::RS_TSTAT) & wdata_q[abt_pkg::TS_ZDS];
  wire zd_clr = zs_wr | ~run | wdog_stop; // RULE_02 RULE_04
  wire reload = (cnt_q == abt_pkg::CNT_ZERO) & ~tctrl_q[abt_pkg::TC_ZD_ROLL];

  // configuration registers written at the acknowledge edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tctrl_q <= abt_pkg::TCTRL_RST;
      tvec_q <= abt_pkg::TVEC_RST;
      pvec_q <= abt_pkg::PVEC_RST;
      cpr_q <= abt_pkg::CPR_RST;
    end else if (wr_stb) begin
      if (rs_q == abt_pkg::RS_TCTRL) begin
        tctrl_q <= wdata_q;
      end else if (rs_q == abt_pkg::RS_TVEC) begin
        tvec_q <= wdata_q;
      end else if (rs_q == abt_pkg::RS_PORT_VEC) begin
        pvec_q <= wdata_q;
      end else if (rs_q == abt_pkg::RS_CPR_H) begin
        cpr_q[23:16] <= wdata_q;
      end else if (rs_q == abt_pkg::RS_CPR_M) begin
        cpr_q[15:8] <= wdata_q;
      end else if (rs_q == abt_pkg::RS_CPR_L) begin
        cpr_q[7:0] <= wdata_q;
      end
    end
  end

  // counter, prescaler and zero detect
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tin_q <= 1'b0;
      cnt_q <= abt_pkg::CNT_ZERO;
      pre_q <= abt_pkg::PRESCALE_ONES;
      zds_q <= 1'b0;
    end else begin
      tin_q <= i_timer_input;
      if (wdog_start) begin
        cnt_q <= cpr_q; // RULE_01
      end else if (cnt_tick) begin
        cnt_q <= reload ? cpr_q : cnt_q - 24'h000001; // RULE_03
      end
      if (wdog_stop || !run) begin
        pre_q <= abt_pkg::PRESCALE_ONES; // RULE_04
      end else if (src_tick && !no_pre) begin
        pre_q <= pre_q - 5'h01; // RULE_06
      end
      // clearing dominates a same-cycle zero detect
      if (zd_clr) begin
        zds_q <= 1'b0; // RULE_20
      end else if (zd_hit) begin
        zds_q <= 1'b1; // RULE_03 RULE_20
      end
    end
  end

  assign o_timer_output = zds_q; // RULE_02 RULE_03
endmodule : abt_device

//--- src/abt_pkg.sv
package abt_pkg;
  // register select map (5-bit select)
  localparam logic [4:0] RS_PORT_VEC = 5'h00;
  localparam logic [4:0] RS_TCTRL = 5'h01;
  localparam logic [4:0] RS_TVEC = 5'h02;
  localparam logic [4:0] RS_CPR_H = 5'h04;
  localparam logic [4:0] RS_CPR_M = 5'h05;
  localparam logic [4:0] RS_CPR_L = 5'h06;
  localparam logic [4:0] RS_CNT_H = 5'h09;
  localparam logic [4:0] RS_CNT_M = 5'h0A;
  localparam logic [4:0] RS_CNT_L = 5'h0B;
  localparam logic [4:0] RS_TSTAT = 5'h0C;
  // timer control fields
  localparam int TC_ENABLE = 0;
  localparam int TC_CLK_LO = 1;
  localparam int TC_CLK_HI = 2;
  localparam int TC_WDOG = 3;
  localparam int TC_ZD_ROLL = 4;
  localparam int TS_ZDS = 0;
  // reset values
  localparam logic [7:0] TVEC_RST = 8'h0F;
  localparam logic [7:0] PVEC_RST = 8'h0F;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [23:0] CPR_RST = 24'hFFFFFF;
  localparam logic [4:0] PRESCALE_ONES = 5'h1F;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  // bus timing, in device clocks from the acknowledge edge
  localparam logic [1:0] RECOVERY_CLKS = 2'h3;
  // strobe kinds for the host side
  localparam logic [1:0] KIND_CS = 2'h0;
  localparam logic [1:0] KIND_PORT_INT_ACK = 2'h1;
  localparam logic [1:0] KIND_TIMER_INT_ACK = 2'h2;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
endpackage : abt_pkg

//--- src/abt_bus_if.sv
interface abt_bus_if;
  logic chip_select_n;
  logic port_int_ack_n;
  logic timer_int_ack_n;
  logic [4:0] register_select;
  logic read_write_n;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic transfer_ack_o;
  logic transfer_ack_oe;
  // resolved wires: data pulled high when idle, acknowledge pulled up
  logic [7:0] data;
  logic transfer_ack_n;
  assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : abt_pkg::BUS_IDLE);
  assign transfer_ack_n = transfer_ack_oe ? transfer_ack_o : 1'b1;
  modport dev (
    input chip_select_n, port_int_ack_n, timer_int_ack_n, register_select, read_write_n, data,
    output dev_data_o, dev_data_oe, transfer_ack_o, transfer_ack_oe
  );
  modport host (
    output chip_select_n, port_int_ack_n, timer_int_ack_n, register_select, read_write_n,
    output host_data_o, host_data_oe,
    input data, transfer_ack_n
  );
endinterface : abt_bus_if

//--- src/abt_host.sv
// host end: one strobe at a time, inputs held until acknowledged
module abt_host (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  abt_bus_if.host bus,
  input wire logic i_req,
  input wire logic [1:0] i_kind,
  input wire logic i_read,
  input wire logic [4:0] i_sel,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT_ACK = 2'b01,
    HS_WAIT_REL = 2'b10
  } abt_host_state_t;

  abt_host_state_t state_q;
  logic [1:0] kind_q;
  logic rw_n_q;
  logic [4:0] sel_q;
  logic [7:0] wdata_q;
  logic done_q;
  logic [7:0] rdata_q;

  wire strobe = (state_q == HS_WAIT_ACK);
  wire acked = ~bus.transfer_ack_n;

  // request capture and handshake
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= HS_IDLE;
      kind_q <= abt_pkg::KIND_CS;
      rw_n_q <= 1'b1;
      sel_q <= 5'h00;
      wdata_q <= 8'h00;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (i_req) begin
            kind_q <= i_kind;
            rw_n_q <= i_read | (i_kind != abt_pkg::KIND_CS);
            sel_q <= i_sel;
            wdata_q <= i_wdata;
            state_q <= HS_WAIT_ACK;
          end
        end
        HS_WAIT_ACK: begin
          if (acked) begin
            rdata_q <= bus.data;
            state_q <= HS_WAIT_REL;
          end
        end
        HS_WAIT_REL: begin
          // wait until the device has pulled the acknowledge back up
          if (!acked) begin
            done_q <= 1'b1;
            state_q <= HS_IDLE;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // at most one strobe, decoded from the held kind
  assign bus.chip_select_n = ~(strobe & (kind_q == abt_pkg::KIND_CS)); // RULE_07
  assign bus.port_int_ack_n = ~(strobe & (kind_q == abt_pkg::KIND_PORT_INT_ACK));
  assign bus.timer_int_ack_n = ~(strobe & (kind_q == abt_pkg::KIND_TIMER_INT_ACK));
  assign bus.register_select = sel_q; // RULE_15
  assign bus.read_write_n = rw_n_q;
  assign bus.host_data_o = wdata_q;
  assign bus.host_data_oe = strobe & ~rw_n_q;
  assign o_busy = (state_q != HS_IDLE);
  assign o_done = done_q;
  assign o_rdata = rdata_q;
endmodule : abt_host

//--- test/abt_bus_monitor.sv
// bus watcher on the joined interface; sees only resolved and enable signals
module abt_bus_monitor (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic chip_select_n,
  input wire logic port_int_ack_n,
  input wire logic timer_int_ack_n,
  input wire logic [4:0] register_select,
  input wire logic read_write_n,
  input wire logic dev_data_oe,
  input wire logic [7:0] data,
  input wire logic transfer_ack_oe,
  input wire logic transfer_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // all strobes idle; ack enable may linger two edges after a release (ack, then pull-up)
  wire strobes_hi = chip_select_n && port_int_ack_n && timer_int_ack_n;

  AST_ONE_STROBE: assert property ($countones({chip_select_n, port_int_ack_n, timer_int_ack_n}) >= 2)
    else $error("more than one strobe asserted");
  AST_CS_ACK: assert property ($fell(chip_select_n) |-> ##[1:4] !transfer_ack_n)
    else $error("no acknowledge after select");
  // the host lifts its strobe one edge after the acknowledge, so check that ack only rises once idle
  AST_ACK_STANDS: assert property ($rose(transfer_ack_n) |-> strobes_hi)
    else $error("acknowledge dropped while selected");
  // vector cycles drive data an edge before the acknowledge, which exercises this hold
  AST_DATA_HELD: assert property ((dev_data_oe && !strobes_hi) ##1 !strobes_hi |-> $stable(data))
    else $error("read data moved while selected");
  AST_RELEASE: assert property ($rose(strobes_hi)
    |-> transfer_ack_n ##1 transfer_ack_n ##1 !transfer_ack_oe)
    else $error("acknowledge not negated then released");
  AST_IACK_SEQ: assert property (($fell(port_int_ack_n) || $fell(timer_int_ack_n))
    |-> transfer_ack_n ##2 (dev_data_oe && transfer_ack_n) ##1 !transfer_ack_n)
    else $error("vector or acknowledge timing wrong");
  AST_INPUT_HOLD: assert property ((!chip_select_n && transfer_ack_n)
    |=> $stable(register_select) && $stable(read_write_n))
    else $error("selects moved before acknowledge");
  AST_CYCLE_GAP: assert property ($fell(transfer_ack_n) |=> (!$fell(transfer_ack_n))[*3])
    else $error("cycles closer than four clocks");
  AST_IDLE_QUIET: assert property (strobes_hi ##1 strobes_hi ##1 strobes_hi |-> !transfer_ack_oe)
    else $error("acknowledge driven while idle");

  CV_READ: cover property ($fell(chip_select_n) && read_write_n);
  CV_TIMER_INT_ACK: cover property ($fell(timer_int_ack_n));
  CV_PORT_INT_ACK: cover property ($fell(port_int_ack_n));
endmodule : abt_bus_monitor

//--- test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_nrst, i_req, i_read, i_timer_input, o_busy, o_done, o_timer_output;
  logic [1:0] i_kind;
  logic [4:0] i_sel;
  logic [7:0] i_wdata, o_rdata, rd;
  int miscompares, samples_checked, cycles;

  abt_bus_if u_bus ();
  abt_device u_abt_device (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(u_bus),
    .i_timer_input(i_timer_input), .o_timer_output(o_timer_output));
  abt_host u_abt_host (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(u_bus), .i_req(i_req),
    .i_kind(i_kind), .i_read(i_read), .i_sel(i_sel), .i_wdata(i_wdata), .o_busy(o_busy),
    .o_done(o_done), .o_rdata(o_rdata));
  abt_bus_monitor u_abt_bus_monitor (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .chip_select_n(u_bus.chip_select_n), .port_int_ack_n(u_bus.port_int_ack_n),
    .timer_int_ack_n(u_bus.timer_int_ack_n), .register_select(u_bus.register_select),
    .read_write_n(u_bus.read_write_n), .dev_data_oe(u_bus.dev_data_oe), .data(u_bus.data),
    .transfer_ack_oe(u_bus.transfer_ack_oe), .transfer_ack_n(u_bus.transfer_ack_n));

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  // hang guard: whole run needs well under a thousand clocks
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one host transfer; request raised only while the host is idle
  task automatic xfer(input logic [1:0] kind, input logic rdn, input logic [4:0] sel, input logic [7:0] wd);
    int n;
    while (o_busy !== 1'b0) tick(1);
    i_kind = kind;
    i_read = rdn;
    i_sel = sel;
    i_wdata = wd;
    i_req = 1'b1;
    tick(1);
    i_req = 1'b0;
    for (n = 0; n < 40 && o_done !== 1'b1; n++) tick(1);
    rd = o_rdata;
  endtask : xfer

  // input pulses wide enough to survive the input synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      i_timer_input = 1'b1;
      tick(4);
      i_timer_input = 1'b0;
      tick(4);
    end
  endtask : pulse

  task automatic t_vectors;
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_TVEC, 8'h00);
    chk(rd, abt_pkg::TVEC_RST);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_PORT_VEC, 8'h00);
    chk(rd, abt_pkg::PVEC_RST);
    xfer(abt_pkg::KIND_CS, 1'b1, 5'h1F, 8'h00);
    chk(rd, 8'h00);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TVEC, 8'hA5);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_PORT_VEC, 8'h3C);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_TVEC, 8'h00);
    chk(rd, 8'hA5);
    // acknowledge cycles carry misleading selects on purpose
    xfer(abt_pkg::KIND_TIMER_INT_ACK, 1'b1, abt_pkg::RS_PORT_VEC, 8'h00);
    chk(rd, 8'hA5);
    xfer(abt_pkg::KIND_PORT_INT_ACK, 1'b1, abt_pkg::RS_TVEC, 8'h00);
    chk(rd, 8'h3C);
  endtask : t_vectors

  task automatic t_watchdog;
    int n;
    logic seen;
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_CPR_H, 8'h00);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_CPR_M, 8'h00);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_CPR_L, 8'h04);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h1B);
    i_timer_input = 1'b1;
    for (n = 0; n < 30 && o_timer_output !== 1'b1; n++) tick(1);
    chk(o_timer_output, 1'b1);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_TSTAT, 8'h00);
    chk(rd[0], 1'b1);
    i_timer_input = 1'b0;
    tick(3);
    chk(o_timer_output, 1'b0);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_TSTAT, 8'h00);
    chk(rd[0], 1'b0);
    // long preload, input dropped well before zero
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_CPR_L, 8'h40);
    i_timer_input = 1'b1;
    seen = 1'b0;
    repeat (20) begin
      tick(1);
      seen = seen | o_timer_output;
    end
    i_timer_input = 1'b0;
    tick(2);
    chk(seen | o_timer_output, 1'b0);
  endtask : t_watchdog

  task automatic t_event;
    logic [7:0] c0;
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h07);
    pulse(1);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h06);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_CNT_L, 8'h00);
    c0 = rd;
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h07);
    pulse(3);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h06);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_CNT_L, 8'h00);
    chk(rd, 8'(c0 - 8'h03));
    // pulses while halted must not count
    pulse(2);
    xfer(abt_pkg::KIND_CS, 1'b1, abt_pkg::RS_CNT_L, 8'h00);
    chk(rd, 8'(c0 - 8'h03));
  endtask : t_event

  // prescaled watchdog: one count per 32 clocks; a drop must put the prescaler back to ones
  task automatic t_prescale;
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_CPR_L, 8'h02);
    xfer(abt_pkg::KIND_CS, 1'b0, abt_pkg::RS_TCTRL, 8'h19);
    repeat (2) begin
      i_timer_input = 1'b1;
      tick(40);
      chk(o_timer_output, 1'b0);
      tick(30);
      chk(o_timer_output, 1'b1);
      i_timer_input = 1'b0;
      tick(3);
      chk(o_timer_output, 1'b0);
    end
  endtask : t_prescale

  task automatic wrap_up;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    i_nrst = 1'b0;
    i_req = 1'b0;
    i_kind = abt_pkg::KIND_CS;
    i_read = 1'b1;
    i_sel = 5'h00;
    i_wdata = 8'h00;
    i_timer_input = 1'b0;
    tick(2);
    i_nrst = 1'b1;
    t_vectors();
    t_watchdog();
    t_event();
    t_prescale();
    wrap_up();
  end
endmodule : testbench
